// ==== hw/aisc_top.sv ====
`timescale 1ns/1ps
`include "aisc_regs.svh"
// Contract
// - Analog-assigned pin loses its digital function.
// - Pull-high disconnected on analog-assigned pins.
// - Analog selection overrides pin direction setting.
// - Codes 0000, 0100, 11xx route external pin.
// - Other source codes route listed internal signals.
// - Internal source switches external path off.
// - Start needs low-high-low pulse on start bit.
// - Busy cleared when conversion completes.
// - Completion sets request flag, enabled raises interrupt.
// - Conversion clock is system clock divided by 2^n.
// - Conversion: 4 sample plus 12 convert ticks.
// - Result bytes aligned by format select bit.
// - Results unchanged while converter power is off.
module aisc_top
  import aisc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        startControl,
  input  wire logic        converter_power_enable,
  input  wire logic        result_format_select,
  input  wire logic [3:0]  input_source_select,
  input  wire logic [3:0]  external_channel_select,
  input  wire logic [2:0]  conversion_clock_divider_select,
  input  wire logic        interruptEnable,
  input  wire logic        interruptFlagClear,
  input  wire logic [15:0] pin_function_select_high,
  input  wire logic [15:0] pin_function_select_low,
  input  wire logic [15:0] pinPullHighEnable,
  input  wire logic [15:0] pinDirectionInput,
  input  wire logic [11:0] converterDataIn,
  output logic [15:0]      pinDigitalEnable,
  output logic [15:0]      pinPullHighActive,
  output logic [15:0]      pinInputMode,
  output logic             externalChannelEnable,
  output logic [3:0]       externalChannelIndex,
  output aisc_int_src_t    internalSource,
  output logic             conversionClockTick,
  output logic             sampleActive,
  output logic             conversionActive,
  output logic             conversion_busy_flag,
  output logic             interruptRequestFlag,
  output logic             interruptOut,
  output logic [7:0]       result_high_byte,
  output logic [7:0]       result_low_byte
);

  // ************************************************************
  // Pin ownership.
  // ************************************************************

  genvar gPin;
  generate
    for (gPin = 0; gPin < 16; gPin++) begin : gPinCtl
      logic isAnalog;
      assign isAnalog = {pin_function_select_high[gPin], pin_function_select_low[gPin]}
                        == `AISC_PIN_FUNC_ANALOG;
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          pinDigitalEnable[gPin]  <= 1'b1;
          pinPullHighActive[gPin] <= 1'b0;
          pinInputMode[gPin]      <= 1'b1;
        end else begin
          pinDigitalEnable[gPin]  <= !isAnalog;
          pinPullHighActive[gPin] <= pinPullHighEnable[gPin] && !isAnalog;
          pinInputMode[gPin]      <= pinDirectionInput[gPin] || isAnalog;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Input routing.
  // ************************************************************

  aisc_int_src_t intSrc_d;
  logic          extSel_d;

  always_comb begin
    intSrc_d = AISC_INT_NONE;
    extSel_d = 1'b0;
    if (input_source_select[3:2] == `AISC_SRC_TOP_EXT) begin
      extSel_d = 1'b1;
    end else if (input_source_select[3:2] == `AISC_SRC_TOP_GND) begin
      intSrc_d = AISC_INT_GND;
    end else begin
      case (input_source_select)
        `AISC_SRC_EXT0:   extSel_d = 1'b1;
        `AISC_SRC_EXT1:   extSel_d = 1'b1;
        `AISC_SRC_AVDD:   intSrc_d = AISC_INT_AVDD;
        `AISC_SRC_AVDD_2: intSrc_d = AISC_INT_AVDD_2;
        `AISC_SRC_AVDD_4: intSrc_d = AISC_INT_AVDD_4;
        `AISC_SRC_PGA:    intSrc_d = AISC_INT_PGA;
        `AISC_SRC_PGA_2:  intSrc_d = AISC_INT_PGA_2;
        `AISC_SRC_PGA_4:  intSrc_d = AISC_INT_PGA_4;
        default:          intSrc_d = AISC_INT_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      externalChannelEnable <= 1'b0;
      externalChannelIndex  <= 4'h0;
      internalSource        <= AISC_INT_NONE;
    end else begin
      externalChannelEnable <= extSel_d;
      externalChannelIndex  <= extSel_d ? external_channel_select : 4'h0;
      internalSource        <= intSrc_d;
    end
  end

  // ************************************************************
  // Conversion clock prescaler.
  // ************************************************************

  logic [6:0] prescale_q;
  logic [6:0] divMask;
  logic       tick;

  assign divMask = 7'(~(`AISC_PRESCALE_ONES << conversion_clock_divider_select));
  assign tick    = (prescale_q & divMask) == divMask;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prescale_q <= 7'h00;
    end else if (!converter_power_enable) begin
      prescale_q <= 7'h00;
    end else begin
      prescale_q <= prescale_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conversionClockTick <= 1'b0;
    end else begin
      conversionClockTick <= tick && converter_power_enable;
    end
  end

  // ************************************************************
  // Start detection.
  // ************************************************************

  logic startHigh_q;
  logic startPulse;

  assign startPulse = startHigh_q && !startControl && converter_power_enable;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      startHigh_q <= 1'b0;
    end else begin
      startHigh_q <= startControl;
    end
  end

  // ************************************************************
  // Conversion sequencer.
  // ************************************************************

  aisc_state_t state_q;
  logic [4:0]  tickCount_q;
  logic        done;

  assign done = (state_q == AISC_CONVERT) && tick && converter_power_enable
                && (tickCount_q == `AISC_TOTAL_TICKS - 5'h01);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= AISC_IDLE;
      tickCount_q <= 5'h00;
    end else if (!converter_power_enable) begin
      state_q     <= AISC_IDLE;
      tickCount_q <= 5'h00;
    end else begin
      case (state_q)
        AISC_IDLE: begin
          tickCount_q <= 5'h00;
          if (startPulse) begin
            state_q <= AISC_SAMPLE;
          end
        end
        AISC_SAMPLE: begin
          if (startPulse) begin
            tickCount_q <= 5'h00;
          end else if (tick) begin
            tickCount_q <= tickCount_q + 5'h01;
            if (tickCount_q == `AISC_SAMPLE_TICKS - 5'h01) begin
              state_q <= AISC_CONVERT;
            end
          end
        end
        AISC_CONVERT: begin
          if (startPulse) begin
            state_q     <= AISC_SAMPLE;
            tickCount_q <= 5'h00;
          end else if (done) begin
            state_q     <= AISC_IDLE;
            tickCount_q <= 5'h00;
          end else if (tick) begin
            tickCount_q <= tickCount_q + 5'h01;
          end
        end
        default: begin
          state_q     <= AISC_IDLE;
          tickCount_q <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sampleActive     <= 1'b0;
      conversionActive <= 1'b0;
    end else begin
      sampleActive     <= state_q == AISC_SAMPLE;
      conversionActive <= state_q == AISC_CONVERT;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conversion_busy_flag <= 1'b0;
    end else if (!converter_power_enable) begin
      conversion_busy_flag <= 1'b0;
    end else if (startPulse) begin
      conversion_busy_flag <= 1'b1;
    end else if (done) begin
      conversion_busy_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Completion flag and interrupt.
  // ************************************************************

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      interruptRequestFlag <= 1'b0;
    end else if (done) begin
      interruptRequestFlag <= 1'b1;
    end else if (interruptFlagClear) begin
      interruptRequestFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      interruptOut <= 1'b0;
    end else begin
      interruptOut <= interruptEnable && (interruptRequestFlag || done);
    end
  end

  // ************************************************************
  // Result bytes.
  // ************************************************************

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      result_high_byte <= `AISC_RESULT_RESET;
      result_low_byte  <= `AISC_RESULT_RESET;
    end else if (done) begin
      if (result_format_select) begin
        result_high_byte <= {4'h0, converterDataIn[11:8]};
        result_low_byte  <= converterDataIn[7:0];
      end else begin
        result_high_byte <= converterDataIn[11:4];
        result_low_byte  <= {converterDataIn[3:0], 4'h0};
      end
    end
  end

endmodule

// ==== hw/aisc_regs.svh ====
`ifndef AISC_REGS_SVH
`define AISC_REGS_SVH

// Source select codes and masks.
`define AISC_SRC_EXT0      4'h0
`define AISC_SRC_AVDD      4'h1
`define AISC_SRC_AVDD_2    4'h2
`define AISC_SRC_AVDD_4    4'h3
`define AISC_SRC_EXT1      4'h4
`define AISC_SRC_PGA       4'h5
`define AISC_SRC_PGA_2     4'h6
`define AISC_SRC_PGA_4     4'h7
`define AISC_SRC_TOP_GND   2'h2
`define AISC_SRC_TOP_EXT   2'h3

// Pin function code that claims a pin for analog use.
`define AISC_PIN_FUNC_ANALOG 2'h3

// Conversion timing in conversion clock ticks.
`define AISC_SAMPLE_TICKS  5'h04
`define AISC_CONVERT_TICKS 5'h0c
`define AISC_TOTAL_TICKS   5'h10

// Result reset value and prescaler all-ones mask.
`define AISC_RESULT_RESET  8'h00
`define AISC_PRESCALE_ONES 7'h7f

`endif

// ==== hw/aisc_pkg.sv ====
package aisc_pkg;

  typedef enum logic [1:0] {
    AISC_IDLE,
    AISC_SAMPLE,
    AISC_CONVERT
  } aisc_state_t;

  typedef enum logic [2:0] {
    AISC_INT_NONE,
    AISC_INT_AVDD,
    AISC_INT_AVDD_2,
    AISC_INT_AVDD_4,
    AISC_INT_PGA,
    AISC_INT_PGA_2,
    AISC_INT_PGA_4,
    AISC_INT_GND
  } aisc_int_src_t;

endpackage

// ==== tb/aisc_top_sva.sv ====
`timescale 1ns/1ps
module aisc_top_sva (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        startControl,
  input wire logic        converter_power_enable,
  input wire logic        result_format_select,
  input wire logic [3:0]  input_source_select,
  input wire logic [2:0]  conversion_clock_divider_select,
  input wire logic        interruptEnable,
  input wire logic [11:0] converterDataIn,
  input wire logic        externalChannelEnable,
  input wire logic        conversionClockTick,
  input wire logic        conversion_busy_flag,
  input wire logic        interruptRequestFlag,
  input wire logic        interruptOut,
  input wire logic [7:0]  result_high_byte,
  input wire logic [7:0]  result_low_byte
);
  logic busyPrev_q;
  logic pwrPrev_q;
  logic done;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busyPrev_q <= 1'b0;
      pwrPrev_q  <= 1'b0;
    end else begin
      busyPrev_q <= conversion_busy_flag;
      pwrPrev_q  <= converter_power_enable;
    end
  end
  assign done = busyPrev_q & ~conversion_busy_flag & converter_power_enable & pwrPrev_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  AST_START: assert property (
    $past(reset_n) && $past(startControl) && !startControl && converter_power_enable
    |=> conversion_busy_flag) else $error("busy not set by start pulse");
  AST_NOSTART: assert property (
    !conversion_busy_flag && !($past(startControl) && !startControl)
    |=> !conversion_busy_flag) else $error("busy set without start pulse");
  AST_LEN: assert property (
    $rose(conversion_busy_flag) && conversion_clock_divider_select == 3'h0 |->
    conversion_busy_flag[*8] ##1 conversion_busy_flag[*8] ##1 !conversion_busy_flag)
    else $error("conversion length wrong");
  AST_DONE: assert property (done |-> interruptRequestFlag)
    else $error("request flag not set at completion");
  AST_IRQ: assert property (done && interruptEnable |=> interruptOut)
    else $error("interrupt not raised");
  AST_FMT: assert property (done |-> ({result_high_byte, result_low_byte} ==
    ($past(result_format_select) ? {4'h0, $past(converterDataIn)} :
     {$past(converterDataIn), 4'h0})))
    else $error("result bytes wrong");
  AST_HOLD: assert property (!pwrPrev_q |-> $stable({result_high_byte, result_low_byte}))
    else $error("results changed while powered off");
  AST_TICK: assert property (
    $past(converter_power_enable, 2) && $past(converter_power_enable) &&
    $past(conversion_clock_divider_select, 2) == 3'h0 &&
    $past(conversion_clock_divider_select) == 3'h0 |-> conversionClockTick)
    else $error("undivided tick missing");
  AST_EXT: assert property ($past(reset_n) &&
    ($past(input_source_select) & 4'hb) != 4'h0 &&
    ($past(input_source_select) & 4'hc) != 4'hc |-> !externalChannelEnable)
    else $error("external path on with internal source");
endmodule
bind aisc_top aisc_top_sva chk (
  .clk_sys                         (clk_sys),
  .reset_n                         (reset_n),
  .startControl                    (startControl),
  .converter_power_enable          (converter_power_enable),
  .result_format_select            (result_format_select),
  .input_source_select             (input_source_select),
  .conversion_clock_divider_select (conversion_clock_divider_select),
  .interruptEnable                 (interruptEnable),
  .converterDataIn                 (converterDataIn),
  .externalChannelEnable           (externalChannelEnable),
  .conversionClockTick             (conversionClockTick),
  .conversion_busy_flag            (conversion_busy_flag),
  .interruptRequestFlag            (interruptRequestFlag),
  .interruptOut                    (interruptOut),
  .result_high_byte                (result_high_byte),
  .result_low_byte                 (result_low_byte)
);

// ==== tb/aisc_top_bench.sv ====
`timescale 1ns/1ps
module aisc_top_bench
  import aisc_pkg::*;
;
  logic          clk_sys = 1'b0;
  logic          reset_n, startControl, converter_power_enable, result_format_select;
  logic          interruptEnable, interruptFlagClear;
  logic [3:0]    input_source_select, external_channel_select, externalChannelIndex;
  logic [2:0]    conversion_clock_divider_select;
  logic [15:0]   pin_function_select_high, pin_function_select_low;
  logic [15:0]   pinPullHighEnable, pinDirectionInput;
  logic [15:0]   pinDigitalEnable, pinPullHighActive, pinInputMode;
  logic [11:0]   converterDataIn;
  logic          externalChannelEnable, conversionClockTick, sampleActive;
  logic          conversionActive, conversion_busy_flag, interruptRequestFlag, interruptOut;
  logic [7:0]    result_high_byte, result_low_byte;
  logic [15:0]   saved;
  aisc_int_src_t internalSource;
  int            error_cnt = 0;
  int            compares = 0;
  int            n;
  aisc_top dut (
    .clk_sys                         (clk_sys),
    .reset_n                         (reset_n),
    .startControl                    (startControl),
    .converter_power_enable          (converter_power_enable),
    .result_format_select            (result_format_select),
    .input_source_select             (input_source_select),
    .external_channel_select         (external_channel_select),
    .conversion_clock_divider_select (conversion_clock_divider_select),
    .interruptEnable                 (interruptEnable),
    .interruptFlagClear              (interruptFlagClear),
    .pin_function_select_high        (pin_function_select_high),
    .pin_function_select_low         (pin_function_select_low),
    .pinPullHighEnable               (pinPullHighEnable),
    .pinDirectionInput               (pinDirectionInput),
    .converterDataIn                 (converterDataIn),
    .pinDigitalEnable                (pinDigitalEnable),
    .pinPullHighActive               (pinPullHighActive),
    .pinInputMode                    (pinInputMode),
    .externalChannelEnable           (externalChannelEnable),
    .externalChannelIndex            (externalChannelIndex),
    .internalSource                  (internalSource),
    .conversionClockTick             (conversionClockTick),
    .sampleActive                    (sampleActive),
    .conversionActive                (conversionActive),
    .conversion_busy_flag            (conversion_busy_flag),
    .interruptRequestFlag            (interruptRequestFlag),
    .interruptOut                    (interruptOut),
    .result_high_byte                (result_high_byte),
    .result_low_byte                 (result_low_byte)
  );
  always #12.5 clk_sys = ~clk_sys;
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task bound(input int k);
    if (k >= 3000) begin
      error_cnt++;
      end_sim;
    end
  endtask
  task t_pins;
    pin_function_select_high = 16'hff0f;
    pin_function_select_low = 16'hf0f3;
    pinPullHighEnable = 16'h5a5a;
    pinDirectionInput = 16'h00f0;
    cyc(2);
    chk(pinDigitalEnable, 16'h0ffc);
    chk(pinPullHighActive, 16'h0a58);
    chk(pinInputMode, 16'hf0f3);
  endtask
  task t_route;
    logic e;
    external_channel_select = 4'h9;
    for (int s = 0; s < 16; s++) begin
      input_source_select = 4'(s);
      cyc(2);
      e = (s == 0) || (s == 4) || (s >= 12);
      chk({externalChannelEnable, externalChannelIndex}, e ? 16'h19 : 16'h0);
      chk(internalSource, 16'(e ? 0 : (s >= 8) ? 7 : (s > 4) ? s - 1 : s));
    end
  endtask
  task t_conv(input logic f, input logic [2:0] d);
    int sa;
    int ca;
    result_format_select = f;
    conversion_clock_divider_select = d;
    converterDataIn = 12'ha5c ^ {9'h0, d};
    startControl = 1'b1;
    cyc(3);
    chk(conversion_busy_flag, 16'h0);
    startControl = 1'b0;
    cyc(1);
    chk(conversion_busy_flag, 16'h1);
    n = 0;
    sa = 0;
    ca = 0;
    while (conversion_busy_flag !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
      sa += int'(sampleActive);
      ca += int'(conversionActive);
    end
    bound(n);
    chk(16'(n > (15 << d) && n <= (16 << d)), 16'h1);
    chk(16'(sa > (3 << d) && sa <= (4 << d)), 16'h1);
    chk(16'(ca), 16'(12 << d));
    chk(interruptRequestFlag, 16'h1);
    chk({result_high_byte, result_low_byte}, f ? {4'h0, converterDataIn} : {converterDataIn, 4'h0});
    cyc(1);
    chk(interruptOut, interruptEnable);
    interruptFlagClear = 1'b1;
    cyc(1);
    interruptFlagClear = 1'b0;
    cyc(1);
    chk(interruptRequestFlag, 16'h0);
  endtask
  task t_clk;
    for (int d = 0; d < 8; d++) begin
      conversion_clock_divider_select = 3'(d);
      cyc(260);
      for (n = 0; conversionClockTick !== 1'b1 && n < 3000; n++) cyc(1);
      bound(n);
      cyc(1);
      for (n = 1; conversionClockTick !== 1'b1 && n < 3000; n++) cyc(1);
      bound(n);
      chk(16'(n), 16'(1 << d));
    end
  endtask
  task t_off;
    saved = {result_high_byte, result_low_byte};
    converterDataIn = 12'h3c1;
    startControl = 1'b1;
    cyc(1);
    startControl = 1'b0;
    cyc(10);
    converter_power_enable = 1'b0;
    cyc(2);
    chk(conversion_busy_flag, 16'h0);
    startControl = 1'b1;
    cyc(1);
    startControl = 1'b0;
    cyc(20);
    chk(conversion_busy_flag, 16'h0);
    chk({result_high_byte, result_low_byte}, saved);
  endtask
  initial begin
    reset_n = 1'b0;
    {startControl, converter_power_enable, result_format_select} = 3'h0;
    {interruptEnable, interruptFlagClear, conversion_clock_divider_select} = 5'h0;
    {input_source_select, external_channel_select, converterDataIn} = 20'h0;
    {pin_function_select_high, pin_function_select_low} = 32'h0;
    {pinPullHighEnable, pinDirectionInput} = 32'h0;
    cyc(6);
    reset_n = 1'b1;
    converter_power_enable = 1'b1;
    interruptEnable = 1'b1;
    cyc(4);
    t_pins;
    t_route;
    t_conv(1'b0, 3'h0);
    interruptEnable = 1'b0;
    t_conv(1'b1, 3'h5);
    t_clk;
    t_off;
    end_sim;
  end
endmodule
